/* File: verilog/rx_ctrl_pkg.sv */
// Purpose: Shared constants for the IF receiver control register bank
// Assumes: 24-bit serial frames, 16-bit registers, 40 MHz mclk
// Notes: Register numbers are the 5-bit numbers carried in each frame

package rx_ctrl_pkg;

  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int CHIP_MSB = 23;
  localparam int CHIP_LSB = 21;
  localparam int REGNUM_MSB = 20;
  localparam int REGNUM_LSB = 16;
  localparam logic [4:0] FRAME_DONE_COUNT = 5'h18;
  localparam logic [4:0] FRAME_COUNT_MAX = 5'h1F;

  // Register numbers
  localparam logic [4:0] REG_ENABLE = 5'h01;
  localparam logic [4:0] REG_FILTER = 5'h02;
  localparam logic [4:0] REG_FSOURCE = 5'h03;
  localparam logic [4:0] REG_GAIN = 5'h04;
  localparam logic [4:0] REG_LIMIT = 5'h05;
  localparam logic [4:0] REG_CALSTAT = 5'h06;
  localparam logic [4:0] REG_READSEL = 5'h07;
  localparam logic [4:0] REG_BLOCKER = 5'h12;

  // Reset values
  localparam logic [15:0] ENABLE_RESET = 16'hBFBE;
  localparam logic [15:0] FILTER_RESET = 16'hC585;
  localparam logic [15:0] FSOURCE_RESET = 16'h869F;
  localparam logic [15:0] GAIN_RESET = 16'h3430;
  localparam logic [15:0] LIMIT_RESET = 16'hA904;
  localparam logic [15:0] BLOCKER_RESET = 16'hF05C;
  localparam logic [7:0] CAL_WORD_RESET = 8'h85;

  // Enable register fields
  localparam int EN_DET2 = 15;
  localparam int EN_AUX = 13;
  localparam int EN_LNA = 11;
  localparam int EN_RFGAIN = 10;
  localparam int EN_MIXER = 9;
  localparam int EN_BPF = 8;
  localparam int EN_IFGAIN = 7;
  localparam int EN_DET1 = 5;
  localparam int EN_DET3 = 4;
  localparam int EN_LOOP_N = 3;
  localparam int EN_AMP3_OFF = 2;
  localparam int EN_AMP2_OFF = 1;
  localparam int EN_BBUF = 0;

  // Filter register fields
  localparam int FLT_SIDEBAND = 15;
  localparam int FLT_BW_LSB = 13;
  localparam int FLT_EXT = 12;
  localparam int FLT_OVR = 10;
  localparam int FLT_CAL = 9;
  localparam int FLT_WORD_LSB = 0;

  // Other fields
  localparam int SRC_SEL = 11;
  localparam int GAIN_MODE_LSB = 12;
  localparam int GAIN_CAP = 11;
  localparam int GAIN_BW_LSB = 8;
  localparam int GAIN_ATT_LSB = 6;
  localparam int GAIN_LVL_LSB = 0;
  localparam int LIMIT_LSB = 9;
  localparam int BLK_MODE = 6;
  localparam int BLK_REF_LSB = 3;
  localparam int BLK_BW_LSB = 0;
  localparam int READSEL_LSB = 11;

  // Gain mode codes
  localparam logic [3:0] MODE_INTERNAL = 4'h3;
  localparam logic [3:0] MODE_EXTERNAL = 4'hC;

  // Calibration run time
  localparam int MCLK_PERIOD_NS = 25;
  localparam int CAL_TIME_NS = 10000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

/* File: verilog/serial_link_port.sv */
// Purpose: Serial-clock side of the register port: shifter and readout
// Assumes: Serial clock may stop between frames
// Notes: Frame word and count stay stable while select is high
`timescale 1ns/1ps
`default_nettype none

module serial_link_port
  import rx_ctrl_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic serial_select_n,
  input wire logic serial_in,
  input wire logic read_armed,
  input wire logic [15:0] read_word,
  output logic [23:0] frame_bits,
  output logic [4:0] frame_count,
  output logic serial_out
);

  logic in_frame_reg; // Cleared by select high, marks first edge
  logic [23:0] shift_reg; // Incoming bits, newest in bit 0
  logic [4:0] count_reg; // Pulses seen in this frame
  logic [15:0] out_shift_reg; // Remaining readout bits
  logic out_reg; // Serial output bit

  // Frame marker; the frame's own select ends it with no clock needed
  always_ff @(posedge sclk or negedge rst_n or posedge serial_select_n) begin
    if (!rst_n) begin
      in_frame_reg <= 1'b0;
    end else if (serial_select_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // Shift in on rising edges while select is low, MSB first
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h000000;
      count_reg <= 5'h00;
    end else if (!serial_select_n) begin
      shift_reg <= {shift_reg[22:0], serial_in};
      if (!in_frame_reg) begin
        // First pulse of a new frame restarts the count
        count_reg <= 5'h01;
      end else if (count_reg != FRAME_COUNT_MAX) begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  // Readout shifts the selected word out, changing on the rising edge.
  // Select high clears it at once: a cut readout must not leave a bit on the line.
  always_ff @(posedge sclk or negedge rst_n or posedge serial_select_n) begin
    if (!rst_n) begin
      out_shift_reg <= 16'h0000;
      out_reg <= 1'b0;
    end else if (serial_select_n) begin
      // Frame over, with or without all its pulses
      out_shift_reg <= 16'h0000;
      out_reg <= 1'b0;
    end else if (read_armed) begin
      if (!in_frame_reg) begin
        out_reg <= read_word[15];
        out_shift_reg <= {read_word[14:0], 1'b0};
      end else begin
        out_reg <= out_shift_reg[15];
        out_shift_reg <= {out_shift_reg[14:0], 1'b0};
      end
    end else begin
      // Idle line sits low outside a readout
      out_reg <= 1'b0;
    end
  end

  assign frame_bits = shift_reg;
  assign frame_count = count_reg;
  assign serial_out = out_reg;

endmodule

`default_nettype wire

/* File: verilog/if_receiver_control_regs.sv */
// Purpose: Control and status register bank of an RF-to-IF receiver
// Assumes: Host is the serial master and makes the serial clock
// Notes: Loads happen in the mclk domain after select returns high
`timescale 1ns/1ps
`default_nettype none

module if_receiver_control_regs
  import rx_ctrl_pkg::*;
#(
  parameter logic [2:0] CHIP_ADDR = 3'h0, // Arbitrary chip address of this part
  parameter logic [7:0] STORE_WORD = 8'h85, // Word held in the one-time store
  parameter int CAL_RUN_CYCLES = CAL_CYCLES // Calibration run length
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic detector_two_on,
  output logic aux_output_on,
  output logic low_noise_amp_on,
  output logic rf_gain_stage_on,
  output logic mixer_on,
  output logic bandpass_on,
  output logic if_gain_stage_on,
  output logic detector_one_on,
  output logic detector_three_on,
  output logic gain_loop_on_n,
  output logic third_amp_off,
  output logic second_amp_off,
  output logic baseband_buffer_on,
  output logic sideband_choice,
  output logic [1:0] bandwidth_choice,
  output logic offchip_filter_choice,
  output logic [7:0] filter_freq_word,
  output logic [3:0] gain_mode_code,
  output logic gain_loop_active,
  output logic external_gain_active,
  output logic loop_cap_fitted,
  output logic [2:0] gain_loop_bandwidth,
  output logic [1:0] third_stage_atten,
  output logic [5:0] target_output_level,
  output logic [2:0] if_gain_limit,
  output logic blocker_handling_on,
  output logic [2:0] blocker_reference_level,
  output logic [2:0] blocker_loop_bandwidth,
  output logic cal_busy
);

  localparam int CNT_W = $clog2(CAL_RUN_CYCLES + 1);

  typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} cal_state_e;

  // Link side wires
  logic [23:0] frame_bits; // Stable while select is high
  logic [4:0] frame_count; // Pulses in the last frame
  logic serial_out_link; // Readout bit from the link flop

  // Select synchroniser and edge history
  logic sel_meta_reg; // First stage, read only by the second
  logic sel_sync_reg; // Synchronised select
  logic sel_prev_reg; // Previous synchronised select
  logic frame_end; // One-cycle pulse when select has returned high

  // Decoded frame fields
  logic frame_full;
  logic chip_match;
  logic [4:0] frame_regnum;
  logic [15:0] frame_data;
  logic write_go; // A complete write frame to this chip
  logic readout_end; // End of the frame that carried read data

  // Writable registers
  logic [15:0] enable_reg;
  logic [15:0] filter_reg;
  logic [15:0] fsource_reg;
  logic [15:0] gain_reg;
  logic [15:0] limit_reg;
  logic [15:0] blocker_reg;

  // Readback path
  logic read_armed_reg; // Next frame is a readout
  logic [4:0] read_sel_reg; // Register chosen for readout
  logic [15:0] read_mux; // Combinational pick of read data
  logic [15:0] read_word_reg; // Frozen word offered to the link

  // Calibration engine state
  cal_state_e cal_state_reg;
  cal_state_e cal_state_next;
  logic [CNT_W-1:0] cal_count_reg;
  logic cal_start; // Zero-to-one write of the trigger bit
  logic cal_done_flag_reg;
  logic cal_overflow_flag_reg;
  logic [7:0] calibrated_freq_word_reg;

  // Derived output flops
  logic [7:0] freq_word_reg;
  logic loop_active_reg;
  logic ext_gain_reg;

  // Serial-clock side lives in its own module
  serial_link_port link_port (
    .sclk(sclk),
    .rst_n(rst_n),
    .serial_select_n(serial_select_n),
    .serial_in(serial_in),
    .read_armed(read_armed_reg),
    .read_word(read_word_reg),
    .frame_bits(frame_bits),
    .frame_count(frame_count),
    .serial_out(serial_out_link)
  );

  // Select passes two flops before any mclk logic looks at it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
    end else begin
      sel_meta_reg <= serial_select_n;
      sel_sync_reg <= sel_meta_reg;
      sel_prev_reg <= sel_sync_reg;
    end
  end

  // Rising select ends a frame; link data is quiet by then
  assign frame_end = sel_sync_reg & ~sel_prev_reg;

  // Only exactly twenty-four pulses make a valid frame
  assign frame_full = (frame_count == FRAME_DONE_COUNT);
  assign chip_match = (frame_bits[CHIP_MSB:CHIP_LSB] == CHIP_ADDR);
  assign frame_regnum = frame_bits[REGNUM_MSB:REGNUM_LSB];
  assign frame_data = frame_bits[DATA_BITS-1:0];

  // A readout frame never writes, whatever the host shifted in
  assign write_go = frame_end & frame_full & chip_match & ~read_armed_reg;
  assign readout_end = frame_end & read_armed_reg;

  // Enable register; reserved and diagnostic bits are stored as written
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= ENABLE_RESET;
    end else if (write_go && frame_regnum == REG_ENABLE) begin
      enable_reg <= frame_data;
    end
  end

  // Filter and sideband register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filter_reg <= FILTER_RESET;
    end else if (write_go && frame_regnum == REG_FILTER) begin
      filter_reg <= frame_data;
    end
  end

  // Frequency word source register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fsource_reg <= FSOURCE_RESET;
    end else if (write_go && frame_regnum == REG_FSOURCE) begin
      fsource_reg <= frame_data;
    end
  end

  // Gain loop register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= GAIN_RESET;
    end else if (write_go && frame_regnum == REG_GAIN) begin
      gain_reg <= frame_data;
    end
  end

  // IF gain limit register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      limit_reg <= LIMIT_RESET;
    end else if (write_go && frame_regnum == REG_LIMIT) begin
      limit_reg <= frame_data;
    end
  end

  // Blocker detection register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blocker_reg <= BLOCKER_RESET;
    end else if (write_go && frame_regnum == REG_BLOCKER) begin
      blocker_reg <= frame_data;
    end
  end

  // Register 7 arms a readout; the next frame carries the data out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_armed_reg <= 1'b0;
      read_sel_reg <= 5'h00;
    end else if (write_go && frame_regnum == REG_READSEL) begin
      read_armed_reg <= 1'b1;
      read_sel_reg <= frame_data[READSEL_LSB +: 5];
    end else if (readout_end) begin
      // Any frame after arming consumes the readout
      read_armed_reg <= 1'b0;
    end
  end

  // Read data mux; unmapped numbers read as zero
  always_comb begin
    unique case (read_sel_reg)
      REG_ENABLE: read_mux = enable_reg;
      REG_FILTER: read_mux = filter_reg;
      REG_FSOURCE: read_mux = fsource_reg;
      REG_GAIN: read_mux = gain_reg;
      REG_LIMIT: read_mux = limit_reg;
      REG_CALSTAT: begin
        // Upper six bits are reserved and read zero
        read_mux = {6'h00, cal_overflow_flag_reg, cal_done_flag_reg,
                    calibrated_freq_word_reg};
      end
      REG_BLOCKER: read_mux = blocker_reg;
      default: read_mux = 16'h0000;
    endcase
  end

  // Word is refreshed only while select has been high for two samples.
  // The link reads it without a synchroniser: it is frozen during frames.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_word_reg <= 16'h0000;
    end else if (sel_sync_reg && sel_prev_reg) begin
      read_word_reg <= read_mux;
    end
  end

  // Only a zero-to-one change of the trigger bit starts a run
  assign cal_start = write_go && (frame_regnum == REG_FILTER) &&
                     !filter_reg[FLT_CAL] && frame_data[FLT_CAL];

  // Calibration sequencer next state
  always_comb begin
    cal_state_next = cal_state_reg;
    unique case (cal_state_reg)
      CAL_IDLE: begin
        if (cal_start) begin
          cal_state_next = CAL_RUN;
        end
      end
      CAL_RUN: begin
        // A fresh trigger restarts; otherwise finish on count end
        if (!cal_start && cal_count_reg == '0) begin
          cal_state_next = CAL_IDLE;
        end
      end
    endcase
  end

  // Calibration state and run counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= CAL_IDLE;
      cal_count_reg <= '0;
    end else begin
      cal_state_reg <= cal_state_next;
      if (cal_start) begin
        cal_count_reg <= CNT_W'(CAL_RUN_CYCLES - 1);
      end else if (cal_state_reg == CAL_RUN && cal_count_reg != '0) begin
        cal_count_reg <= cal_count_reg - 1'b1;
      end
    end
  end

  // Status flags: end flag drops at start and rises at finish.
  // Overflow marks a run cut short by a new trigger.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_done_flag_reg <= 1'b1;
      cal_overflow_flag_reg <= 1'b1;
      calibrated_freq_word_reg <= CAL_WORD_RESET;
    end else if (cal_start) begin
      cal_done_flag_reg <= 1'b0;
      cal_overflow_flag_reg <= (cal_state_reg == CAL_RUN);
    end else if (cal_state_reg == CAL_RUN && cal_count_reg == '0) begin
      cal_done_flag_reg <= 1'b1;
      // No analog loop here; the factory word stands for the result
      calibrated_freq_word_reg <= STORE_WORD;
    end
  end

  // Effective centre word for the filter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      freq_word_reg <= CAL_WORD_RESET;
    end else if (!filter_reg[FLT_OVR]) begin
      freq_word_reg <= calibrated_freq_word_reg;
    end else if (fsource_reg[SRC_SEL]) begin
      freq_word_reg <= filter_reg[FLT_WORD_LSB +: 8];
    end else begin
      freq_word_reg <= STORE_WORD;
    end
  end

  // Gain mode decode; unlisted codes leave both modes off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loop_active_reg <= 1'b0;
      ext_gain_reg <= 1'b0;
    end else begin
      loop_active_reg <= (gain_reg[GAIN_MODE_LSB +: 4] == MODE_INTERNAL) &&
                         !enable_reg[EN_LOOP_N];
      ext_gain_reg <= (gain_reg[GAIN_MODE_LSB +: 4] == MODE_EXTERNAL);
    end
  end

  // Analog controls are register bits, so each comes from a flop
  assign detector_two_on = enable_reg[EN_DET2];
  assign aux_output_on = enable_reg[EN_AUX];
  assign low_noise_amp_on = enable_reg[EN_LNA];
  assign rf_gain_stage_on = enable_reg[EN_RFGAIN];
  assign mixer_on = enable_reg[EN_MIXER];
  assign bandpass_on = enable_reg[EN_BPF];
  assign if_gain_stage_on = enable_reg[EN_IFGAIN];
  assign detector_one_on = enable_reg[EN_DET1];
  assign detector_three_on = enable_reg[EN_DET3];
  assign gain_loop_on_n = enable_reg[EN_LOOP_N];
  assign third_amp_off = enable_reg[EN_AMP3_OFF];
  assign second_amp_off = enable_reg[EN_AMP2_OFF];
  assign baseband_buffer_on = enable_reg[EN_BBUF];

  // Filter controls
  assign sideband_choice = filter_reg[FLT_SIDEBAND];
  assign bandwidth_choice = filter_reg[FLT_BW_LSB +: 2];
  assign offchip_filter_choice = filter_reg[FLT_EXT];
  assign filter_freq_word = freq_word_reg;

  // Gain loop controls
  assign gain_mode_code = gain_reg[GAIN_MODE_LSB +: 4];
  assign gain_loop_active = loop_active_reg;
  assign external_gain_active = ext_gain_reg;
  assign loop_cap_fitted = gain_reg[GAIN_CAP];
  assign gain_loop_bandwidth = gain_reg[GAIN_BW_LSB +: 3];
  assign third_stage_atten = gain_reg[GAIN_ATT_LSB +: 2];
  assign target_output_level = gain_reg[GAIN_LVL_LSB +: 6];
  assign if_gain_limit = limit_reg[LIMIT_LSB +: 3];

  // Blocker controls
  assign blocker_handling_on = blocker_reg[BLK_MODE];
  assign blocker_reference_level = blocker_reg[BLK_REF_LSB +: 3];
  assign blocker_loop_bandwidth = blocker_reg[BLK_BW_LSB +: 3];

  // Status and serial output
  assign cal_busy = (cal_state_reg == CAL_RUN);
  assign serial_out = serial_out_link;

endmodule

`default_nettype wire

/* File: sim/host_master.sv */
// Purpose: Serial master model that stands in for the host controller
// Assumes: 12 ns serial clock, made only inside frames
// Notes: Readout bits are captured while the clock is low
`timescale 1ns/1ps
`default_nettype none

module host_master (
  output logic sclk,
  output logic serial_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  // Idle bus: clock low, select high
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end

  // One frame of n pulses, MSB first; q holds the first 16 bits seen back
  task automatic frame(input logic [23:0] f, input int n, output logic [15:0] q);
    q = 16'h0000;
    #5 serial_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in = f[23 - i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
      if (i < 16) begin
        q[15 - i] = serial_out;
      end
    end
    #6 serial_select_n = 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    serial_in = ~serial_in;
    // Long gap lets the load land before the next frame
    #250;
  endtask
endmodule

`default_nettype wire

/* File: sim/rx_props.sv */
// Purpose: Port checks for the receiver control register bank
// Assumes: Serial clock idle while select is high
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none

module rx_props
  import rx_ctrl_pkg::*;
#(parameter int CAL_RUN_CYCLES = 8)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serial_select_n,
  input wire logic serial_out,
  input wire logic gain_loop_on_n,
  input wire logic sideband_choice,
  input wire logic [1:0] bandwidth_choice,
  input wire logic [3:0] gain_mode_code,
  input wire logic gain_loop_active,
  input wire logic external_gain_active,
  input wire logic [5:0] target_output_level,
  input wire logic [2:0] if_gain_limit,
  input wire logic [2:0] blocker_reference_level,
  input wire logic cal_busy
);
  logic [15:0] busy_cnt; // Length of the current run
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // A restart keeps counting, so only a floor on the length is checked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 16'h0000;
    end else if (cal_busy) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end

  a_loop_follows: assert property (
    gain_loop_active == $past(gain_mode_code == MODE_INTERNAL && !gain_loop_on_n))
    else $error("gain loop flag wrong");
  a_ext_follows: assert property (
    external_gain_active == $past(gain_mode_code == MODE_EXTERNAL))
    else $error("external gain flag wrong");
  a_mode_excl: assert property (
    !(gain_loop_active && external_gain_active)) else $error("both gain modes on");
  a_load_after_sel: assert property (
    $changed({sideband_choice, bandwidth_choice, gain_mode_code}) |->
      serial_select_n && $past(serial_select_n, 2)) else $error("load while selected");
  a_quiet_frame: assert property (
    !serial_select_n [*2] |->
      $stable({target_output_level, if_gain_limit, blocker_reference_level}))
    else $error("register moved mid frame");
  a_cal_start_sel: assert property (
    $rose(cal_busy) |-> $past(serial_select_n, 2)) else $error("run began mid frame");
  a_cal_length: assert property (
    $fell(cal_busy) |-> busy_cnt >= CAL_RUN_CYCLES) else $error("run too short");
  a_sdo_idle: assert property (
    serial_select_n |-> !serial_out) else $error("readout outside frame");
endmodule

`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the receiver control register bank
// Assumes: Register model below mirrors every accepted frame
// Notes: Short calibration run and non-zero chip address
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [2:0] CHIP = 3'h5;
  localparam logic [7:0] SW = 8'h5A; // Arbitrary store word
  logic mclk, rst_n, sclk, serial_select_n, serial_in, serial_out;
  logic detector_two_on, aux_output_on, low_noise_amp_on, rf_gain_stage_on, mixer_on;
  logic bandpass_on, if_gain_stage_on, detector_one_on, detector_three_on, gain_loop_on_n;
  logic third_amp_off, second_amp_off, baseband_buffer_on, sideband_choice, cal_busy;
  logic offchip_filter_choice, loop_cap_fitted, gain_loop_active, external_gain_active;
  logic blocker_handling_on;
  logic [1:0] bandwidth_choice, third_stage_atten;
  logic [7:0] filter_freq_word;
  logic [3:0] gain_mode_code;
  logic [2:0] gain_loop_bandwidth, if_gain_limit, blocker_reference_level;
  logic [2:0] blocker_loop_bandwidth;
  logic [5:0] target_output_level;
  logic [15:0] m [32]; // Register model, unmapped reads as zero
  logic [4:0] al [8] = '{1, 2, 3, 4, 5, 6, 18, 20};
  int errors, checked, seed, r;
  logic ovf, run; // Model calibration state
  logic [15:0] cq; // Word captured by a cut readout

  if_receiver_control_regs #(.CHIP_ADDR(CHIP), .STORE_WORD(SW), .CAL_RUN_CYCLES(200))
    u_dut (.*);
  host_master u_host (.sclk(sclk), .serial_select_n(serial_select_n),
    .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Pins against the model
  task pins;
    logic [7:0] fw;
    fw = m[2][10] ? (m[3][11] ? m[2][7:0] : SW) : m[6][7:0];
    chk("enable", {m[1][15], m[1][13], m[1][11:7], m[1][5:0]}, {detector_two_on,
      aux_output_on, low_noise_amp_on, rf_gain_stage_on, mixer_on, bandpass_on,
      if_gain_stage_on, detector_one_on, detector_three_on, gain_loop_on_n,
      third_amp_off, second_amp_off, baseband_buffer_on});
    chk("filter", {m[2][15:12], fw}, {sideband_choice, bandwidth_choice,
      offchip_filter_choice, filter_freq_word});
    chk("gain", m[4], {gain_mode_code, loop_cap_fitted, gain_loop_bandwidth,
      third_stage_atten, target_output_level});
    chk("misc", {m[5][11:9], m[18][6:0], m[4][15:12] == 4'h3 && !m[1][3],
      m[4][15:12] == 4'hC}, {if_gain_limit, blocker_handling_on, blocker_reference_level,
      blocker_loop_bandwidth, gain_loop_active, external_gain_active});
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d, input logic [2:0] c = CHIP,
      input int n = 24);
    logic [15:0] q;
    u_host.frame({c, a, d}, n, q);
    if (c === CHIP && n == 24 && a inside {1, 2, 3, 4, 5, 18}) begin
      if (a == 2 && !m[2][9] && d[9]) begin
        ovf = run;
        run = 1'b1;
      end
      m[a] = d;
    end
    pins();
  endtask

  // Arm through register 7, then a readout frame
  task rd(input logic [4:0] a);
    logic [15:0] q;
    u_host.frame({CHIP, 5'h07, a, 11'h000}, 24, q);
    u_host.frame(24'h000000, 24, q);
    chk("readback", m[a], q);
  endtask

  task check_all;
    for (int i = 0; i < 8; i++) rd(al[i]);
  endtask

  task do_reset;
    m = '{default: 16'h0000};
    m[1] = 16'hBFBE;
    m[2] = 16'hC585;
    m[3] = 16'h869F;
    m[4] = 16'h3430;
    m[5] = 16'hA904;
    m[6] = 16'h0385;
    m[18] = 16'hF05C;
    run = 1'b0;
    @(negedge mclk) rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  task wait_cal;
    for (int k = 0; k < 400 && cal_busy !== 1'b0; k++) @(negedge mclk);
    if (cal_busy !== 1'b0) begin
      errors++;
      end_of_test();
    end else begin
      m[6] = {6'h00, ovf, 1'b1, SW};
      run = 1'b0;
    end
  endtask

  initial begin
    errors = 0;
    checked = 0;
    seed = 36;
    ovf = 1'b0;
    rst_n = 1'b0;
    do_reset();
    pins();
    check_all();
    // Refused: wrong chip, short frame, read-only and unbuilt registers
    wr(4, 16'hC5A5, 3'h2);
    wr(4, 16'hC5A5, CHIP, 23);
    wr(6, 16'h0000);
    wr(20, 16'h1234);
    // Unlisted gain mode code is stored but turns neither mode on
    wr(4, 16'h5430);
    // Cut readout of eight pulses; the line must drop once select is high
    u_host.frame({CHIP, 5'h07, 5'h02, 11'h000}, 24, cq);
    u_host.frame(24'h000000, 8, cq);
    chk("cut_readback", {m[2][15:8], 8'h00}, cq);
    chk("sdo_idle", 16'h0000, serial_out);
    check_all();
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      wr(1, (r[15:0] & 16'hAFBF) | 16'h1000);
      r = $random(seed);
      wr(2, (r[15:0] & 16'hF4FF) | 16'h0100);
      r = $random(seed);
      wr(3, 16'h869F | (r[15:0] & 16'h0800));
      r = $random(seed);
      wr(4, (r[15:0] & 16'h0FFF) | (r[12] ? 16'hC000 : 16'h3000));
      r = $random(seed);
      wr(5, 16'hA104 | (r[15:0] & 16'h0E00));
      r = $random(seed);
      wr(18, 16'hF000 | (r[15:0] & 16'h007F));
    end
    check_all();
    // Start, a repeated one is ignored
    wr(2, 16'hC585);
    wr(2, 16'hC785);
    chk("busy", 1'b1, cal_busy);
    wr(2, 16'hC785);
    wait_cal();
    rd(6);
    // Clear and set again mid run: restart with overflow
    wr(2, 16'hC585);
    wr(2, 16'hC785);
    wr(2, 16'hC585);
    wr(2, 16'hC785);
    wait_cal();
    rd(6);
    wr(2, 16'hC185);
    do_reset();
    pins();
    check_all();
    end_of_test();
  end
endmodule

bind if_receiver_control_regs rx_props #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES)) u_props (.*);

`default_nettype wire
